/* verilog/adc_flag_pkg.sv */
// Constants for the converter status-flag block: register offsets,
// field positions, widths and reset values.
// Assumes a 32-bit register port with byte addresses and one clock.
//
// Summary of operation
// R1 - Only last-result read clears data ready
// R2 - Data ready rises only on stored result
// R3 - Channel read never masks data ready set
// R4 - Disable beside other end still stores result
// R5 - Status read updates general overrun anyway
// R6 - Completion while data ready sets overrun
// R7 - Channel read beside end keeps overrun
// R8 - Disable beside end raises both overruns
// R9 - Channel or last read clears done
// R10 - Status read clears channel overrun unless one is set in that cycle
// R11 - Channel disabled mid-conversion never gets done
// R12 - Channel read clears only its done
// R13 - Sleep takes effect after next conversion
// R14 - Software selects sleep then starts conversion
// R15 - Set beats read-clear in same cycle

package adc_flag_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int N_CHAN    = 8;
  localparam int CH_W      = 3;
  localparam int RESULT_W  = 10;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CHAN_EN   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CHAN_DIS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CHAN_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_LAST      = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_CHAN_RES  = 8'h30;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int MODE_SLEEP_BIT = 0;
  localparam int STAT_DONE_LSB  = 0;
  localparam int STAT_OVR_LSB   = 8;
  localparam int STAT_READY_BIT = 16;
  localparam int STAT_GOVR_BIT  = 17;
  localparam int LAST_CHAN_LSB  = 12;
  localparam int IRQ_READY_BIT  = 0;
  localparam int IRQ_GOVR_BIT   = 1;
  localparam int IRQ_W          = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [N_CHAN-1:0] CHAN_EN_RST  = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RST    = 32'h00000000;

endpackage

/* verilog/sticky_flag.sv */
// One sticky status flag with a set input and a clear input.
// Assumes set and clear are single-cycle terms on the same clock.

`timescale 1ns/1ps
`default_nettype none

module sticky_flag (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Events
  input  wire logic set,
  input  wire logic clr,
  // Flag
  output var  logic q
);

  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1; // R15
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* verilog/adc_status_flags.sv */
// Status-flag logic of an on-chip converter: done, overrun, data
// ready and general overrun flags, result storage, sleep entry.
// Assumes the converter core runs on ref_clk and gives one-cycle
// begin and end pulses with the channel number beside them.

`timescale 1ns/1ps
`default_nettype none

module adc_status_flags (
  // Clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  // Register port
  input  wire logic [adc_flag_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [adc_flag_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output var  logic [adc_flag_pkg::DATA_W-1:0]   reg_rdata,
  // Converter core
  input  wire logic                              conv_begin,
  input  wire logic                              conv_end,
  input  wire logic [adc_flag_pkg::CH_W-1:0]     conv_chan,
  input  wire logic [adc_flag_pkg::RESULT_W-1:0] conv_data,
  output var  logic                              conv_start,
  output var  logic                              sleep_active,
  // Interrupt
  output var  logic                              irq
);

  import adc_flag_pkg::*;

  // All checks share the one clock and stay quiet through reset
  default clocking chk_clk @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] res_off;
  logic              res_hit;
  logic [CH_W-1:0]   res_idx;
  logic              wr_ctrl;
  logic              wr_mode;
  logic              wr_en;
  logic              wr_dis;
  logic              wr_irq_stat;
  logic              wr_irq_mask;
  logic              rd_status;
  logic              rd_last;
  logic              rd_chan_any;

  // Channel result words sit at one base, one word per channel
  assign res_off     = reg_addr - OFF_CHAN_RES;
  assign res_hit     = (res_off[7:5] == 3'h0) && (res_off[1:0] == 2'h0);
  assign res_idx     = res_off[4:2];
  assign wr_ctrl     = reg_wr && (reg_addr == OFF_CTRL);
  assign wr_mode     = reg_wr && (reg_addr == OFF_MODE);
  assign wr_en       = reg_wr && (reg_addr == OFF_CHAN_EN);
  assign wr_dis      = reg_wr && (reg_addr == OFF_CHAN_DIS);
  assign wr_irq_stat = reg_wr && (reg_addr == OFF_IRQ_STAT);
  assign wr_irq_mask = reg_wr && (reg_addr == OFF_IRQ_MASK);
  assign rd_status   = reg_rd && (reg_addr == OFF_STATUS);
  assign rd_last     = reg_rd && (reg_addr == OFF_LAST);
  assign rd_chan_any = reg_rd && res_hit;

  // ---------------------------------------------------------------
  // Channel enables and mode
  // ---------------------------------------------------------------
  logic [N_CHAN-1:0] chan_en;
  logic              sleep_mode;

  // Enable and disable are write-one so bits never race each other
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chan_en <= CHAN_EN_RST;
    end else if (wr_en) begin
      chan_en <= chan_en | reg_wdata[N_CHAN-1:0];
    end else if (wr_dis) begin
      chan_en <= chan_en & ~reg_wdata[N_CHAN-1:0];
    end
  end

  // Sleep selection
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sleep_mode <= 1'b0;
    end else if (wr_mode) begin
      sleep_mode <= reg_wdata[MODE_SLEEP_BIT];
    end
  end

  // Start command pulse to the core
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= wr_ctrl && reg_wdata[CTRL_START_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Running conversion tracking
  // ---------------------------------------------------------------
  logic            busy;
  logic [CH_W-1:0] run_chan;
  logic            aborted;
  logic            store;

  // A disable of the running channel between its begin and end pulses taints its result
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy     <= 1'b0;
      run_chan <= 3'h0;
      aborted  <= 1'b0;
    end else if (conv_begin) begin
      busy     <= 1'b1;
      run_chan <= conv_chan;
      aborted  <= 1'b0;
    end else if (conv_end) begin
      busy     <= 1'b0;
      aborted  <= 1'b0;
    end else if (busy && wr_dis && reg_wdata[run_chan]) begin
      aborted  <= 1'b1; // R11
    end
  end

  // Result counts only for an enabled, untainted channel; a disable
  // of some other channel in this cycle does not block it
  assign store = conv_end && chan_en[conv_chan] && !aborted; // R2 R4 R11

  // ---------------------------------------------------------------
  // Result storage
  // ---------------------------------------------------------------
  logic [RESULT_W-1:0] chan_result [N_CHAN];
  logic [RESULT_W-1:0] last_result_reg;
  logic [CH_W-1:0]     last_chan;

  // Both the channel word and the last word take the result
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      last_result_reg <= 10'h000;
      last_chan       <= 3'h0;
    end else if (store) begin
      last_result_reg <= conv_data; // R4
      last_chan       <= conv_chan;
    end
  end

  // Per-channel result words
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < N_CHAN; i++) begin
        chan_result[i] <= 10'h000;
      end
    end else if (store) begin
      chan_result[conv_chan] <= conv_data; // R4
    end
  end

  // ---------------------------------------------------------------
  // Per-channel done and overrun flags
  // ---------------------------------------------------------------
  logic [N_CHAN-1:0] done;
  logic [N_CHAN-1:0] ovr;
  logic [N_CHAN-1:0] done_set;
  logic [N_CHAN-1:0] done_clr;
  logic [N_CHAN-1:0] ovr_set;

  generate
    for (genvar g = 0; g < N_CHAN; g++) begin : g_chan
      // Done is cleared by its own word or by the last word
      assign done_set[g] = store && (conv_chan == g);
      assign done_clr[g] = (rd_chan_any && (res_idx == g)) ||
                           (rd_last && (last_chan == g)); // R9 R12
      // Overrun only when a new result lands on an unread one
      assign ovr_set[g]  = done_set[g] && done[g]; // R8

      sticky_flag u_done (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .set     (done_set[g]),
        .clr     (done_clr[g]),
        .q       (done[g])
      );

      sticky_flag u_ovr (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .set     (ovr_set[g]),
        .clr     (rd_status), // R10
        .q       (ovr[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Global data ready and general overrun
  // ---------------------------------------------------------------
  logic data_ready_flag;
  logic general_overrun_flag;
  logic govr_set;

  // Channel reads never touch data ready; only the last word does
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_ready_flag <= 1'b0;
    end else if (store) begin
      data_ready_flag <= 1'b1; // R2 R3 R4 R15
    end else if (rd_last) begin
      data_ready_flag <= 1'b0; // R1
    end
  end

  // Any stored result over an unread one is a general overrun
  assign govr_set = store && data_ready_flag; // R6 R7 R8

  // Status read always updates: set on a new overrun, else clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      general_overrun_flag <= 1'b0;
    end else if (govr_set) begin
      general_overrun_flag <= 1'b1; // R5 R15
    end else if (rd_status) begin
      general_overrun_flag <= 1'b0; // R5
    end
  end

  // ---------------------------------------------------------------
  // Sleep entry
  // ---------------------------------------------------------------
  // Sleep waits for a conversion end; idle selection does nothing
  // until software starts one, so select sleep then start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sleep_active <= 1'b0;
    end else if (!sleep_mode || conv_start) begin
      sleep_active <= 1'b0;
    end else if (conv_end) begin
      sleep_active <= 1'b1; // R13 R14
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_w1c;

  assign irq_ev  = {govr_set, store};
  assign irq_w1c = wr_irq_stat ? reg_wdata[IRQ_W-1:0] : 2'h0;

  // Sticky events, write one to clear, event beats clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= irq_ev | (irq_stat & ~irq_w1c);
    end
  end

  // Mask register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end

  // Registered level output, updated on the same edge as the status bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_ev | (irq_stat & ~irq_w1c)) & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  // Unmapped addresses read as zero
  always_comb begin
    next_rdata = RDATA_RST;
    if (res_hit) begin
      next_rdata[RESULT_W-1:0] = chan_result[res_idx];
    end else begin
      case (reg_addr)
        OFF_MODE:      next_rdata[MODE_SLEEP_BIT] = sleep_mode;
        OFF_CHAN_STAT: next_rdata[N_CHAN-1:0] = chan_en;
        OFF_STATUS: begin
          next_rdata[STAT_DONE_LSB +: N_CHAN] = done;
          next_rdata[STAT_OVR_LSB +: N_CHAN]  = ovr;
          next_rdata[STAT_READY_BIT]          = data_ready_flag;
          next_rdata[STAT_GOVR_BIT]           = general_overrun_flag;
        end
        OFF_LAST: begin
          next_rdata[RESULT_W-1:0]           = last_result_reg;
          next_rdata[LAST_CHAN_LSB +: CH_W]  = last_chan;
        end
        OFF_IRQ_STAT:  next_rdata[IRQ_W-1:0] = irq_stat;
        OFF_IRQ_MASK:  next_rdata[IRQ_W-1:0] = irq_mask;
        default:       next_rdata = RDATA_RST;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= RDATA_RST;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_ready_chan_read: assert property ( // R1
    rd_chan_any && !store |=> data_ready_flag == $past(data_ready_flag))
    else $error("channel read changed data ready");
  chk_ready_no_store: assert property ( // R2
    conv_end && !chan_en[conv_chan] && rd_last |=> !data_ready_flag)
    else $error("data ready left set without a stored result");
  chk_ready_on_store: assert property ( // R3
    store |=> data_ready_flag && last_result_reg == $past(conv_data))
    else $error("stored result did not raise data ready");
  chk_govr_status: assert property ( // R5
    rd_status |=> general_overrun_flag == $past(store && data_ready_flag))
    else $error("general overrun not updated on status read");
  chk_govr_set: assert property ( // R6
    conv_end && chan_en[conv_chan] && !aborted && data_ready_flag
      |=> general_overrun_flag)
    else $error("overwrite did not raise general overrun");
  chk_ovr_both: assert property ( // R8
    store && done[conv_chan] && data_ready_flag
      |=> ovr[$past(conv_chan)] && general_overrun_flag)
    else $error("overrun flags not raised together");
  chk_done_clear: assert property ( // R9
    rd_last && !store |=> !done[$past(last_chan)])
    else $error("last read did not clear done");
  chk_ovr_status: assert property ( // R10
    rd_status && !(store && done[conv_chan]) |=> ovr == 8'h00)
    else $error("status read left a channel overrun set");
  chk_done_disabled: assert property ( // R11
    conv_end && (aborted || !chan_en[conv_chan])
      |=> (done & ~$past(done)) == 8'h00)
    else $error("done set on a disabled channel");
  chk_done_only_own: assert property ( // R12
    1'b1 |=> ($past(done) & ~done & ~$past(done_clr)) == 8'h00)
    else $error("done cleared without its own read");
  chk_sleep_wait: assert property ( // R13
    $rose(sleep_active) |-> $past(conv_end) && $past(sleep_mode))
    else $error("sleep entered without a conversion end");

endmodule

`default_nettype wire

/* sim/adc_core_model.sv */
// Behavioural converter core for the status-flag bench.
// Assumes the bench picks channel and length; data encodes both.

`timescale 1ns/1ps
`default_nettype none

module adc_core_model (
  // Clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  // Start from the flag block, selection from the bench
  input  wire logic                              conv_start,
  input  wire logic [adc_flag_pkg::CH_W-1:0]     sel_chan,
  input  wire logic [7:0]                        sel_len,
  // Core outputs
  output var  logic                              conv_begin,
  output var  logic                              conv_end,
  output var  logic [adc_flag_pkg::CH_W-1:0]     conv_chan,
  output var  logic [adc_flag_pkg::RESULT_W-1:0] conv_data,
  output var  logic [7:0]                        cnt
);
  import adc_flag_pkg::*;

  logic [CH_W-1:0] run_chan;
  logic [7:0]      run_len;

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  // Channel lines invert outside both pulses, data lines outside the end pulse, so a stale value never passes
  always_ff @(posedge ref_clk) begin
    conv_begin <= 1'b0;
    conv_end   <= 1'b0;
    conv_chan  <= ~conv_chan;
    conv_data  <= ~conv_data;
    if (sys_rst) begin
      cnt       <= 8'h00;
      conv_chan <= 3'h0;
      conv_data <= 10'h000;
    end else if (conv_start && cnt == 8'h00) begin
      cnt        <= sel_len;
      run_chan   <= sel_chan;
      run_len    <= sel_len;
      conv_begin <= 1'b1;
      conv_chan  <= sel_chan;
    end else if (cnt == 8'h01) begin
      cnt       <= 8'h00;
      conv_end  <= 1'b1;
      conv_chan <= run_chan;
      conv_data <= {run_chan, run_len[6:0]};
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

`default_nettype wire

/* sim/adc_status_flag_logic_test.sv */
// Self-checking bench for the converter status-flag block.
// Assumes the core model file and the flag package are compiled first.

`timescale 1ns/1ps
`default_nettype none

module adc_status_flag_logic_test;
  import adc_flag_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                ref_clk   = 1'b0;
  logic                sys_rst   = 1'b1;
  logic [ADDR_W-1:0]   reg_addr  = 8'h00;
  logic [DATA_W-1:0]   reg_wdata = 32'h00000000;
  logic                reg_wr    = 1'b0;
  logic                reg_rd    = 1'b0;
  logic [DATA_W-1:0]   reg_rdata;
  logic                conv_begin;
  logic                conv_end;
  logic [CH_W-1:0]     conv_chan;
  logic [RESULT_W-1:0] conv_data;
  logic                conv_start;
  logic                sleep_active;
  logic                irq;
  logic [CH_W-1:0]     sel_chan  = 3'h0;
  logic [7:0]          sel_len   = 8'h08;
  logic [7:0]          cnt;
  logic [DATA_W-1:0]   d;
  int                  n_errors   = 0;
  int                  n_compared = 0;

  always #4 ref_clk = ~ref_clk;

  adc_status_flags adc_status_flags_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_begin(conv_begin), .conv_end(conv_end),
    .conv_chan(conv_chan), .conv_data(conv_data),
    .conv_start(conv_start), .sleep_active(sleep_active), .irq(irq)
  );

  adc_core_model adc_core_model_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .conv_start(conv_start),
    .sel_chan(sel_chan), .sel_len(sel_len), .conv_begin(conv_begin),
    .conv_end(conv_end), .conv_chan(conv_chan), .conv_data(conv_data),
    .cnt(cnt)
  );

  // ------------------------------------------------------------
  // Bus, expectation and timing helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got,
      input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h00000000, got}, {31'h00000000, exp});
  endtask

  function automatic logic [DATA_W-1:0] st(input logic [7:0] dn,
      input logic [7:0] ov, input logic dr, input logic gv);
    return {14'h0000, gv, dr, ov, dn};
  endfunction

  function automatic logic [DATA_W-1:0] res(input logic [2:0] c,
      input logic [7:0] n);
    return {22'h000000, c, n[6:0]};
  endfunction

  function automatic logic [DATA_W-1:0] last(input logic [2:0] c,
      input logic [7:0] n);
    return {17'h00000, c, 2'h0, c, n[6:0]};
  endfunction

  task automatic do_reset(input int n);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (n) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask

  task automatic start(input logic [2:0] c, input logic [7:0] n);
    sel_chan <= c;
    sel_len  <= n;
    wr(OFF_CTRL, 32'h00000001);
  endtask

  // Bounded wait until the core is idle again
  task automatic settle;
    int g;
    g = 0;
    repeat (3) @(negedge ref_clk);
    while (cnt != 8'h00 && g < 300) begin
      @(negedge ref_clk);
      g++;
    end
    repeat (2) @(negedge ref_clk);
  endtask

  // Returns so that the next bus strobe lands beside the end pulse
  task automatic sync;
    int g;
    g = 0;
    repeat (3) @(negedge ref_clk);
    while (cnt != 8'h01 && g < 300) begin
      @(negedge ref_clk);
      g++;
    end
  endtask

  task automatic conv(input logic [2:0] c, input logic [7:0] n);
    start(c, n);
    settle;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_read;
    do_reset(2);
    wr(OFF_CHAN_EN, 32'h00000007);
    conv(3'h1, 8'h0A);
    rchk(OFF_STATUS, st(8'h02, 8'h00, 1'b1, 1'b0));
    rchk(OFF_CHAN_RES + 8'h04, res(3'h1, 8'h0A));
    rchk(OFF_STATUS, st(8'h00, 8'h00, 1'b1, 1'b0));
    rchk(OFF_LAST, last(3'h1, 8'h0A));
    rchk(OFF_STATUS, st(8'h00, 8'h00, 1'b0, 1'b0));
    rchk(8'hFC, 32'h00000000);
    $display("test read done");
  endtask

  task automatic t_ovr;
    do_reset(2);
    wr(OFF_CHAN_EN, 32'h00000003);
    conv(3'h0, 8'h08);
    conv(3'h0, 8'h09);
    rchk(OFF_LAST, last(3'h0, 8'h09));
    start(3'h0, 8'h0A);
    sync;
    rd(OFF_STATUS, d);
    rchk(OFF_STATUS, st(8'h01, 8'h00, 1'b1, 1'b0));
    start(3'h1, 8'h0B);
    sync;
    rd(OFF_STATUS, d);
    rchk(OFF_STATUS, st(8'h03, 8'h00, 1'b1, 1'b1));
    $display("test overrun done");
  endtask

  task automatic t_dis;
    do_reset(2);
    wr(OFF_CHAN_EN, 32'h00000007);
    start(3'h0, 8'h0C);
    sync;
    wr(OFF_CHAN_DIS, 32'h00000002);
    rchk(OFF_STATUS, st(8'h01, 8'h00, 1'b1, 1'b0));
    rchk(OFF_CHAN_RES, res(3'h0, 8'h0C));
    rchk(OFF_LAST, last(3'h0, 8'h0C));
    conv(3'h0, 8'h0D);
    start(3'h0, 8'h0E);
    sync;
    wr(OFF_CHAN_DIS, 32'h00000004);
    rchk(OFF_STATUS, st(8'h01, 8'h01, 1'b1, 1'b1));
    $display("test disable done");
  endtask

  task automatic t_chan;
    do_reset(2);
    wr(OFF_CHAN_EN, 32'h00000007);
    conv(3'h2, 8'h08);
    conv(3'h0, 8'h09);
    conv(3'h1, 8'h0A);
    rchk(OFF_STATUS, st(8'h07, 8'h00, 1'b1, 1'b1));
    start(3'h0, 8'h0B);
    sync;
    rd(OFF_CHAN_RES + 8'h08, d);
    rchk(OFF_STATUS, st(8'h03, 8'h01, 1'b1, 1'b1));
    rchk(OFF_LAST, last(3'h0, 8'h0B));
    start(3'h1, 8'h0C);
    sync;
    rd(OFF_CHAN_RES, d);
    rchk(OFF_STATUS, st(8'h02, 8'h02, 1'b1, 1'b0));
    $display("test channel read done");
  endtask

  task automatic t_abort;
    do_reset(2);
    wr(OFF_CHAN_EN, 32'h00000003);
    conv(3'h0, 8'h08);
    start(3'h1, 8'h14);
    repeat (3) @(negedge ref_clk);
    wr(OFF_CHAN_DIS, 32'h00000002);
    sync;
    rd(OFF_LAST, d);
    rchk(OFF_STATUS, st(8'h00, 8'h00, 1'b0, 1'b0));
    wr(OFF_CHAN_EN, 32'h00000002);
    start(3'h1, 8'h14);
    repeat (3) @(negedge ref_clk);
    wr(OFF_CHAN_DIS, 32'h00000002);
    wr(OFF_CHAN_EN, 32'h00000002);
    sync;
    rd(OFF_CHAN_RES, d);
    rchk(OFF_STATUS, st(8'h00, 8'h00, 1'b0, 1'b0));
    $display("test abort done");
  endtask

  task automatic t_sleep;
    do_reset(2);
    wr(OFF_CHAN_EN, 32'h00000001);
    wr(OFF_MODE, 32'h00000001);
    repeat (5) @(negedge ref_clk);
    chk1(sleep_active, 1'b0);
    conv(3'h0, 8'h08);
    chk1(sleep_active, 1'b1);
    start(3'h0, 8'h08);
    repeat (2) @(negedge ref_clk);
    chk1(sleep_active, 1'b0);
    settle;
    $display("test sleep done");
  endtask

  task automatic t_irq;
    do_reset(2);
    wr(OFF_CHAN_EN, 32'h00000001);
    wr(OFF_IRQ_MASK, 32'h00000001);
    conv(3'h0, 8'h08);
    chk1(irq, 1'b1);
    rchk(OFF_IRQ_STAT, 32'h00000001);
    wr(OFF_IRQ_MASK, 32'h00000000);
    repeat (2) @(negedge ref_clk);
    chk1(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h00000001);
    repeat (2) @(negedge ref_clk);
    chk1(irq, 1'b1);
    wr(OFF_IRQ_STAT, 32'h00000001);
    repeat (2) @(negedge ref_clk);
    chk1(irq, 1'b0);
    // A masked event must not reach the line even for one cycle
    wr(OFF_IRQ_MASK, 32'h00000002);
    rd(OFF_LAST, d);
    start(3'h0, 8'h08);
    sync;
    repeat (2) @(negedge ref_clk);
    chk1(irq, 1'b0);
    settle;
    $display("test interrupt done");
  endtask

  // ------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ------------------------------------------------------------
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(20);
    t_read;
    t_ovr;
    t_dis;
    t_chan;
    t_abort;
    t_sleep;
    t_irq;
    conclude;
  end

  // The run needs several hundred cycles; this cuts a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude;
  end
endmodule

`default_nettype wire
